// [hw/vpd_params.svh]
// Register indices, field positions, reset values and timing figures
`ifndef VPD_PARAMS_SVH
`define VPD_PARAMS_SVH
`define VPD_IDX_REV       6'h00
`define VPD_IDX_DIV_HI    6'h01
`define VPD_IDX_DIV_LO    6'h02
`define VPD_IDX_PHASE     6'h04
`define VPD_IDX_OUT_CTRL  6'h15
`define VPD_IDX_STATUS    6'h16
`define VPD_DIV_HI_RST    8'h69
`define VPD_DIV_LO_RST    4'hd
`define VPD_PHASE_RST     5'h10
`define VPD_DIV_LO_LSB    4
`define VPD_PHASE_LSB     3
`define VPD_EDGE_BIT      5
`define VPD_MODE_LSB      0
`define VPD_ST_PRESENT    0
`define VPD_ST_HORIZONTAL_SYNC_OUTPUT      1
`define VPD_ST_LEN_LSB    12
`define VPD_HORIZONTAL_SYNC_OUTPUT_WIDTH   8'h20
`define VPD_CLK_MHZ       100
`define VPD_LOSS_US       200
`define VPD_RESP_OKAY     2'b00
`define VPD_RESP_SLVERR   2'b10
`endif

// [hw/vpd_pkg.sv]
// Types shared by the pixel clock and output timing block
package vpd_pkg;

  typedef enum logic [1:0] {
    VPD_MODE_SINGLE     = 2'b00,
    VPD_MODE_INTERLEAVE = 2'b01,
    VPD_MODE_PARALLEL   = 2'b10
  } vpd_mode_t;

  typedef struct packed {
    logic       clk;
    logic       hsync;
    logic [7:0] port_a;
    logic [7:0] port_b;
  } vpd_pix_out_t;

  typedef struct packed {
    logic [2:0]  hs_sync;
    logic        hs_lvl;
    logic [19:0] line_cnt;
    logic [19:0] line_len;
    logic        present;
    logic [20:0] acc;
    logic        pix_clk;
    logic        half_clk;
    logic        odd;
    logic        hs_pend;
    logic        hs_out;
    logic [7:0]  hs_cnt;
    logic [7:0]  even_hold;
    logic [7:0]  port_a;
    logic [7:0]  port_b;
    logic [7:0]  div_hi;
    logic [3:0]  div_lo;
    logic [11:0] div_act;
    logic [4:0]  phase;
    logic        edge_rise;
    vpd_mode_t   mode;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } vpd_state_t;

endpackage : vpd_pkg

// [hw/vpd_top.sv]
// Pixel clock synthesizer, sync output timing and register slave
//
// Local design decision: the AXI4-Lite slave port.
`include "vpd_params.svh"
`timescale 1ns/100ps

module vpd_top
  import vpd_pkg::*;
#(
  parameter logic [7:0]  REVISION    = 8'h5a, // Arbitrary value
  parameter logic [19:0] LOSS_CYCLES = 20'(`VPD_LOSS_US * `VPD_CLK_MHZ)
)(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // Video side
  input  wire logic         hsync_in,
  input  wire logic [7:0]   pixel_in,
  output vpd_pix_out_t      pix_out
);

  vpd_state_t  s;
  vpd_state_t  next_s;
  logic        hs_rise;
  logic        tick_rise;
  logic        tick_fall;
  logic        sel_edge;
  logic        wr_go;
  logic        rd_go;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic [12:0] ratio;
  logic [20:0] step;
  logic [20:0] sum;
  logic [24:0] phase_prod;
  logic [33:0] wr_word;

  // Read mux; unmapped indices answer with a slave error
  function automatic logic [33:0] read_word(input logic [5:0] idx, input vpd_state_t st);
    logic [33:0] r;
    r = {`VPD_RESP_OKAY, 32'h0000_0000};
    case (idx)
      `VPD_IDX_REV:      r[7:0] = REVISION;
      `VPD_IDX_DIV_HI:   r[7:0] = st.div_hi;
      `VPD_IDX_DIV_LO:   r[`VPD_DIV_LO_LSB +: 4] = st.div_lo;
      `VPD_IDX_PHASE:    r[`VPD_PHASE_LSB +: 5] = st.phase;
      `VPD_IDX_OUT_CTRL:
      begin
        r[`VPD_EDGE_BIT]        = st.edge_rise;
        r[`VPD_MODE_LSB +: 2]   = st.mode;
      end
      `VPD_IDX_STATUS:
      begin
        r[`VPD_ST_PRESENT]      = st.present;
        r[`VPD_ST_HORIZONTAL_SYNC_OUTPUT]        = st.hs_out;
        r[`VPD_ST_LEN_LSB +: 20] = st.line_len;
      end
      default:           r[33:32] = `VPD_RESP_SLVERR;
    endcase
    return r;
  endfunction : read_word

  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
  assign rd_go         = s_axi_arvalid && !s.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign wr_idx        = s_axi_awaddr[7:2];
  assign rd_idx        = s_axi_araddr[7:2];

  // Dual modes clock out at half the pixel rate
  // Code 11 falls back to single rate, matching its pixel steering
  assign pix_out.clk    = (s.mode == VPD_MODE_INTERLEAVE || s.mode == VPD_MODE_PARALLEL) ?
                          s.half_clk : s.pix_clk;
  assign pix_out.hsync  = s.hs_out;
  assign pix_out.port_a = s.port_a;
  assign pix_out.port_b = s.port_b;

  always_comb
  begin
    next_s = s;
    tick_rise = 1'b0;
    tick_fall = 1'b0;
    wr_word   = read_word(wr_idx, s);

    // Third stage only confirms the second; first stage feeds nothing else
    next_s.hs_sync = {s.hs_sync[1:0], hsync_in};
    hs_rise = 1'b0;
    if (s.hs_sync[2] == s.hs_sync[1])
    begin
      next_s.hs_lvl = s.hs_sync[1];
      hs_rise = s.hs_sync[1] && !s.hs_lvl;
    end

    // Line period measurement and loss detect
    if (hs_rise)
    begin
      next_s.line_len = s.line_cnt;
      next_s.line_cnt = 20'h0_0001;
      next_s.present  = 1'b1;
    end
    else if (s.line_cnt >= LOSS_CYCLES)
    begin
      // clock stops; relock restarts phase, so delay may move
      next_s.present = 1'b0;
      next_s.pix_clk = 1'b0;
    end
    else
    begin
      next_s.line_cnt = s.line_cnt + 20'h0_0001;
    end

    ratio = {1'b0, s.div_act} + 13'h0001;
    // two accumulator overflows per pixel, ratio pixels per line
    step  = {7'h00, ratio, 1'b0};
    sum   = s.acc + step;
    // offset of phase/32 pixel, in half-pixel units of line_len
    phase_prod = {20'h0_0000, s.phase} * {5'h00, s.line_len};

    if (hs_rise)
    begin
      // realign to line start; phase shifts all edges by phase/32 pixel
      next_s.acc = phase_prod[24:4];
    end
    else if (s.present)
    begin
      // Pixel rate is limited to half of aclk by this edge-per-cycle form
      if (sum >= {1'b0, s.line_len})
      begin
        next_s.acc     = sum - {1'b0, s.line_len};
        next_s.pix_clk = !s.pix_clk;
        tick_rise      = !s.pix_clk;
        tick_fall      = s.pix_clk;
      end
      else
      begin
        next_s.acc = sum;
      end
    end

    sel_edge = s.edge_rise ? tick_rise : tick_fall;
    if (sel_edge)
    begin
      if (s.hs_pend)
      begin
        next_s.hs_out  = 1'b1;
        next_s.hs_cnt  = `VPD_HORIZONTAL_SYNC_OUTPUT_WIDTH;
        next_s.hs_pend = 1'b0;
      end
      else if (s.hs_cnt != 8'h00)
      begin
        next_s.hs_cnt = s.hs_cnt - 8'h01;
        if (s.hs_cnt == 8'h01)
        begin
          next_s.hs_out = 1'b0;
        end
      end
    end
    // New sync wins over the consume in the same cycle
    if (hs_rise)
    begin
      next_s.hs_pend = 1'b1;
    end

    if (hs_rise)
    begin
      next_s.odd = 1'b0;
    end
    else if (tick_rise)
    begin
      next_s.odd      = !s.odd;
      next_s.half_clk = !s.half_clk;
      case (s.mode)
        VPD_MODE_INTERLEAVE:
        begin
          if (s.odd)
          begin
            next_s.port_b = pixel_in;
          end
          else
          begin
            next_s.port_a = pixel_in;
          end
        end
        VPD_MODE_PARALLEL:
        begin
          if (s.odd)
          begin
            next_s.port_a = s.even_hold;
            next_s.port_b = pixel_in;
          end
          else
          begin
            next_s.even_hold = pixel_in;
          end
        end
        default:
        begin
          next_s.port_a = pixel_in;
          next_s.port_b = 8'h00;
        end
      endcase
    end

    // Register writes
    if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = wr_word[33:32];
      if (s_axi_wstrb[0])
      begin
        case (wr_idx)
          `VPD_IDX_DIV_HI: next_s.div_hi = s_axi_wdata[7:0];
          `VPD_IDX_DIV_LO:
          begin
            next_s.div_lo  = s_axi_wdata[`VPD_DIV_LO_LSB +: 4];
            // pending upper byte takes effect only here
            next_s.div_act = {s.div_hi, s_axi_wdata[`VPD_DIV_LO_LSB +: 4]};
          end
          `VPD_IDX_PHASE:  next_s.phase = s_axi_wdata[`VPD_PHASE_LSB +: 5];
          `VPD_IDX_OUT_CTRL:
          begin
            next_s.edge_rise = s_axi_wdata[`VPD_EDGE_BIT];
            next_s.mode      = vpd_mode_t'(s_axi_wdata[`VPD_MODE_LSB +: 2]);
          end
          default:         next_s.phase = s.phase;
        endcase
      end
    end

    // Register reads
    if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (rd_go)
    begin
      next_s.rvalid = 1'b1;
      {next_s.rresp, next_s.rdata} = read_word(rd_idx, s);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s         <= '0;
      s.div_hi  <= `VPD_DIV_HI_RST;
      s.div_lo  <= `VPD_DIV_LO_RST;
      s.div_act <= {`VPD_DIV_HI_RST, `VPD_DIV_LO_RST};
      s.phase   <= `VPD_PHASE_RST;
      s.mode    <= VPD_MODE_SINGLE;
    end
    else
    begin
      s <= next_s;
    end
  end

endmodule : vpd_top

// [tb/vpd_sink.sv]
// Downstream capture model: pixel clocks seen per line
`timescale 1ns/100ps

module vpd_sink
  import vpd_pkg::*;
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pixel stream
  input  wire vpd_pix_out_t pix,
  output logic [15:0]       line_clks
);
  logic [15:0] cnt;
  logic        clk_q;
  logic        hs_q;
  logic        rise;

  assign rise = pix.clk && !clk_q;

  // counts only; judged later with one period slack
  always @(posedge aclk)
  begin
    clk_q <= pix.clk;
    hs_q  <= pix.hsync;
    if (!aresetn)
    begin
      cnt       <= 16'h0;
      line_clks <= 16'h0;
    end
    else if (pix.hsync && !hs_q)
    begin
      line_clks <= cnt;
      cnt       <= 16'(rise);
    end
    else
      cnt <= cnt + 16'(rise);
  end
endmodule : vpd_sink

// [tb/vpd_sva.sv]
// Port assertions for the pixel clock and sync output block
`include "vpd_params.svh"
`timescale 1ns/100ps

module vpd_sva
  import vpd_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h00
)(
  // Clock and reset
  input wire logic         aclk,
  input wire logic         aresetn,
  // Register bus
  input wire logic [7:0]   s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic [3:0]   s_axi_wstrb,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic [7:0]   s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  // Video side
  input wire vpd_pix_out_t pix_out
);
  logic [7:0] div_hi;
  logic [3:0] div_lo;
  logic       edge_rise;
  logic       single;
  logic       wr_go;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wstrb[0];

  // Shadow of the divider and output control fields, to judge read-back and sync edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_hi    <= `VPD_DIV_HI_RST;
      div_lo    <= `VPD_DIV_LO_RST;
      edge_rise <= 1'b0;
      single    <= 1'b1;
    end
    else if (wr_go)
    begin
      if (s_axi_awaddr[7:2] == `VPD_IDX_DIV_HI) div_hi <= s_axi_wdata[7:0];
      if (s_axi_awaddr[7:2] == `VPD_IDX_DIV_LO) div_lo <= s_axi_wdata[7:4];
      if (s_axi_awaddr[7:2] == `VPD_IDX_OUT_CTRL)
      begin
        edge_rise <= s_axi_wdata[`VPD_EDGE_BIT];
        single    <= s_axi_wdata[1:0] == 2'h0 || s_axi_wdata[1:0] == 2'h3;
      end
    end
  end

  sequence s_rd(logic [5:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == idx;
  endsequence
  sequence s_wr(logic [5:0] idx);
    s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == idx;
  endsequence

  property p_rev_rd;
    s_rd(6'h00) |=> s_axi_rvalid && s_axi_rdata == {24'h0, REVISION} && s_axi_rresp == 2'h0;
  endproperty
  a_rev_rd: assert property (p_rev_rd) else $error("revision read wrong");
  property p_rev_wr;
    s_wr(6'h00) |=> s_axi_bvalid && s_axi_bresp == 2'h0;
  endproperty
  a_rev_wr: assert property (p_rev_wr) else $error("revision write answer wrong");
  property p_hi_rd;
    s_rd(6'h01) |=> s_axi_rdata[7:0] == $past(div_hi);
  endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("upper divider read wrong");
  property p_lo_rd;
    s_rd(6'h02) |=> s_axi_rdata[7:4] == $past(div_lo);
  endproperty
  a_lo_rd: assert property (p_lo_rd) else $error("lower divider read wrong");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_hs_on_clk;
    single && $past(single) && $changed(pix_out.hsync) |-> $changed(pix_out.clk);
  endproperty
  a_hs_on_clk: assert property (p_hs_on_clk) else $error("sync moved off clock");
  property p_hs_sel;
    single && $past(single) && $rose(pix_out.hsync) |->
      ($past(edge_rise) ? $rose(pix_out.clk) : $fell(pix_out.clk));
  endproperty
  a_hs_sel: assert property (p_hs_sel) else $error("sync on wrong clock edge");
endmodule : vpd_sva

bind vpd_top vpd_sva #(.REVISION(REVISION)) u_vpd_sva (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .pix_out);

// [tb/vpd_top_tb.sv]
// Self-checking bench for the pixel clock and sync output block
`timescale 1ns/100ps

module vpd_top_tb
  import vpd_pkg::*;
;
  localparam int         LINE = 400;
  localparam logic [7:0] REV  = 8'ha7; // Arbitrary value
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, hs_on;
  logic         hsync_in = 1'b0;
  logic [7:0]   pixel_in = 8'h00;
  logic [7:0]   s_axi_awaddr, s_axi_araddr, pa, pb;
  logic [31:0]  s_axi_wdata, s_axi_rdata, d;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, r;
  logic [15:0]  line_clks;
  vpd_pix_out_t pix_out;
  int           mismatches, check_count;

  vpd_top #(.REVISION(REV), .LOSS_CYCLES(20'd2000)) u_vpd_top (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hsync_in, .pixel_in, .pix_out);
  vpd_sink u_vpd_sink (.aclk, .aresetn, .pix(pix_out), .line_clks);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    @(negedge aclk);
    while (!(s_axi_awready && s_axi_wready)) @(negedge aclk);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    @(negedge aclk);
    while (!s_axi_bvalid) @(negedge aclk);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    @(negedge aclk);
    while (!s_axi_arready) @(negedge aclk);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(negedge aclk);
    while (!s_axi_rvalid) @(negedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : rd

  // Line count may land one period either side
  task automatic measure(input int e);
    repeat (3 * LINE) @(posedge aclk);
    @(negedge aclk);
    pa = pix_out.port_a;
    pb = pix_out.port_b;
    chk(32'(line_clks >= 16'(e - 1) && line_clks <= 16'(e + 1)), 32'h1);
    @(posedge aclk);
  endtask : measure

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic t_regs;
    rd(8'h00); chk(d, {24'h0, REV});
    wr(8'h00, 32'hff, 4'h1); chk({30'h0, r}, 32'h0);
    rd(8'h00); chk(d, {24'h0, REV});
    wr(8'h0c, 32'h01, 4'h1); chk({30'h0, r}, 32'h2);
    rd(8'h10); chk(d, 32'h80);
    wr(8'h10, 32'h48, 4'h1); rd(8'h10); chk(d, 32'h48);
    wr(8'h10, 32'h80, 4'h1);
    rd(8'h04); chk(d, 32'h69);
    rd(8'h08); chk({28'h0, d[7:4]}, 32'hd);
    wr(8'h04, 32'h12, 4'h0); rd(8'h04); chk(d, 32'h69);
    rd(8'h0c); chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_div;
    hs_on = 1'b1;
    wr(8'h04, 32'h04, 4'h1); wr(8'h08, 32'hf0, 4'h1); measure(80);
    wr(8'h04, 32'h09, 4'h1); measure(80);
    rd(8'h04); chk(d, 32'h09);
    wr(8'h08, 32'hf0, 4'h1); measure(160);
    $display("test divider done");
  endtask : t_div

  task automatic t_modes;
    wr(8'h54, 32'h20, 4'h1); measure(160);
    rd(8'h54); chk(d, 32'h20);
    wr(8'h54, 32'h01, 4'h1); measure(80);
    chk(32'((8'(pb - pa) inside {[8'h01:8'h04]}) || (8'(pa - pb) inside {[8'h01:8'h04]})), 32'h1);
    wr(8'h54, 32'h02, 4'h1); measure(80);
    chk(32'(8'(pb - pa) inside {[8'h01:8'h04]}), 32'h1);
    wr(8'h54, 32'h00, 4'h1); measure(160);
    chk({24'h0, pb}, 32'h0);
    $display("test modes done");
  endtask : t_modes

  task automatic t_loss;
    hs_on = 1'b0;
    repeat (2600) @(posedge aclk);
    rd(8'h58); chk({31'h0, d[0]}, 32'h0);
    hs_on = 1'b1;
    repeat (LINE) @(posedge aclk);
    measure(160);
    rd(8'h58); chk({31'h0, d[0]}, 32'h1);
    chk({12'h0, d[31:12]}, 32'(LINE));
    $display("test loss done");
  endtask : t_loss

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) pixel_in <= pixel_in + 8'h01;

  initial
  begin
    forever
    begin
      repeat (LINE - 40) @(posedge aclk);
      hsync_in <= hs_on;
      repeat (40) @(posedge aclk);
      hsync_in <= 1'b0;
    end
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, hs_on} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = '0;
    s_axi_wdata = 32'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_div();
    t_modes();
    t_loss();
    give_verdict();
  end
endmodule : vpd_top_tb
